// File: timer_irq_prescale_flags.sv
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
module timer_irq_prescale_flags
   import timer_irq_prescale_flags_pkg::*;
#(
   parameter int unsigned NUM_CHANNELS = CHANNELS
)
(
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic [ADDR_W-1:0] paddr_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [DATA_W-1:0] pwdata_in,
   output logic [DATA_W-1:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic [NUM_CHANNELS-1:0] capture_event_in,
   output logic [COUNT_W-1:0] count_out,
   output logic [NUM_CHANNELS-1:0] compare_event_out,
   output logic irq_out
);

   // --------------------------------------------------------------------
   // Storage
   // --------------------------------------------------------------------
   logic [NUM_CHANNELS-1:0] channel_mode;
   logic timer_enable;
   logic fast_flag_clear_all;
   logic [NUM_CHANNELS-1:0] channel_irq_enable;
   logic overflow_irq_enable;
   logic counter_reset_on_match_enable;
   logic [DIV_SEL_W-1:0] clock_divide_select;
   logic [DIV_SEL_W-1:0] active_divide;
   logic [PRESCALE_W-1:0] prescale_count;
   logic [COUNT_W-1:0] free_running_count;
   logic [NUM_CHANNELS-1:0] channel_event_flags;
   logic counter_overflow_flag;
   logic [COUNT_W-1:0] channel_value [NUM_CHANNELS];
   logic [NUM_CHANNELS-1:0] compare_event;

   logic [INDEX_W-1:0] index;
   logic access;
   logic wr;
   logic rd;
   logic mapped;
   logic is_channel;
   logic [1:0] channel_sel;
   logic tick;
   logic [PRESCALE_W-1:0] divide_mask;
   logic [NUM_CHANNELS-1:0] match;
   logic seven_match;
   logic [NUM_CHANNELS-1:0] fast_clear;
   logic [NUM_CHANNELS-1:0] write_clear;
   logic [DATA_W-1:0] next_read;

   // --------------------------------------------------------------------
   // Helpers
   // --------------------------------------------------------------------
   function automatic logic [DATA_W-1:0] place_channels(input logic [NUM_CHANNELS-1:0] bits);
      logic [DATA_W-1:0] word;
      word = '0;
      word[BIT_CHANNEL_LSB +: NUM_CHANNELS] = bits;
      return word;
   endfunction : place_channels

   function automatic logic [NUM_CHANNELS-1:0] take_channels(input logic [DATA_W-1:0] word);
      return word[BIT_CHANNEL_LSB +: NUM_CHANNELS];
   endfunction : take_channels

   // --------------------------------------------------------------------
   // Bus decode
   // --------------------------------------------------------------------
   assign index = paddr_in[INDEX_LSB +: INDEX_W];
   assign is_channel = (index >= IDX_CHANNEL_VALUE_BASE) && (index <= IDX_CHANNEL_VALUE_LAST) && !index[0];
   assign channel_sel = 2'((index - IDX_CHANNEL_VALUE_BASE) >> 1);

   always_comb
   begin
      mapped = is_channel;
      unique case (index)
         IDX_CHANNEL_MODE,
         IDX_FREE_RUNNING_COUNT,
         IDX_TIMER_SYSTEM_CONTROL_ONE,
         IDX_CHANNEL_IRQ_ENABLE,
         IDX_TIMER_SYSTEM_CONTROL_TWO,
         IDX_CHANNEL_EVENT_FLAGS,
         IDX_OVERFLOW_FLAG_REGISTER:
            mapped = 1'b1;
         default:
            mapped = mapped;
      endcase
   end

   assign pready_out = 1'b1;
   assign pslverr_out = psel_in && penable_in && !mapped;
   assign access = psel_in && penable_in && mapped;
   assign wr = access && pwrite_in;
   assign rd = access && !pwrite_in;

   // --------------------------------------------------------------------
   // Read data, prepared during the setup cycle
   // --------------------------------------------------------------------
   always_comb
   begin
      next_read = '0;
      if (is_channel)
      begin
         next_read[COUNT_W-1:0] = channel_value[channel_sel];
      end
      else
      begin
         unique case (index)
            IDX_CHANNEL_MODE:
               next_read = place_channels(channel_mode);
            IDX_FREE_RUNNING_COUNT:
               next_read[COUNT_W-1:0] = free_running_count;
            IDX_TIMER_SYSTEM_CONTROL_ONE:
            begin
               next_read[BIT_TIMER_ENABLE] = timer_enable;
               next_read[BIT_FAST_FLAG_CLEAR_ALL] = fast_flag_clear_all;
            end
            IDX_CHANNEL_IRQ_ENABLE:
               next_read = place_channels(channel_irq_enable);
            IDX_TIMER_SYSTEM_CONTROL_TWO:
            begin
               next_read[BIT_OVERFLOW_IRQ_ENABLE] = overflow_irq_enable;
               next_read[BIT_COUNTER_RESET_ON_MATCH_ENABLE] = counter_reset_on_match_enable;
               next_read[BIT_CLOCK_DIVIDE_SELECT_LSB +: DIV_SEL_W] = clock_divide_select;
            end
            IDX_CHANNEL_EVENT_FLAGS:
               next_read = place_channels(channel_event_flags);
            IDX_OVERFLOW_FLAG_REGISTER:
               next_read[BIT_COUNTER_OVERFLOW_FLAG] = counter_overflow_flag;
            default:
               next_read = '0;
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         prdata_out <= '0;
      else if (psel_in && !penable_in)
         prdata_out <= next_read;
   end

   // --------------------------------------------------------------------
   // Control registers
   // --------------------------------------------------------------------
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         channel_mode <= RESET_CHANNEL_BITS;
         timer_enable <= 1'b0;
         fast_flag_clear_all <= 1'b0;
      end
      else if (wr && index == IDX_CHANNEL_MODE)
         channel_mode <= take_channels(pwdata_in);
      else if (wr && index == IDX_TIMER_SYSTEM_CONTROL_ONE)
      begin
         timer_enable <= pwdata_in[BIT_TIMER_ENABLE];
         fast_flag_clear_all <= pwdata_in[BIT_FAST_FLAG_CLEAR_ALL];
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         channel_irq_enable <= RESET_CHANNEL_BITS;
      else if (wr && index == IDX_CHANNEL_IRQ_ENABLE)
         channel_irq_enable <= take_channels(pwdata_in);
   end

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         overflow_irq_enable <= 1'b0;
         counter_reset_on_match_enable <= 1'b0;
         clock_divide_select <= RESET_DIVIDE;
      end
      else if (wr && index == IDX_TIMER_SYSTEM_CONTROL_TWO)
      begin
         overflow_irq_enable <= pwdata_in[BIT_OVERFLOW_IRQ_ENABLE];
         counter_reset_on_match_enable <= pwdata_in[BIT_COUNTER_RESET_ON_MATCH_ENABLE];
         clock_divide_select <= pwdata_in[BIT_CLOCK_DIVIDE_SELECT_LSB +: DIV_SEL_W];
      end
   end

   // --------------------------------------------------------------------
   // Prescaler
   // --------------------------------------------------------------------
   // divide by power of two
   assign divide_mask = PRESCALE_W'((8'h01 << active_divide) - 8'h01);
   assign tick = timer_enable && ((prescale_count & divide_mask) == divide_mask);

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         prescale_count <= RESET_PRESCALE;
      else if (!timer_enable || tick)
         prescale_count <= RESET_PRESCALE;
      else
         prescale_count <= prescale_count + 7'h01;
   end

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         active_divide <= RESET_DIVIDE;
      else if (prescale_count == RESET_PRESCALE)
         active_divide <= clock_divide_select;
   end

   // --------------------------------------------------------------------
   // Free-running counter
   // --------------------------------------------------------------------
   // equality compare
   always_comb
   begin
      for (int i = 0; i < NUM_CHANNELS; i++)
         match[i] = tick && channel_mode[i] && (free_running_count == channel_value[i]);
   end
   assign seven_match = match[NUM_CHANNELS-1];

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         free_running_count <= RESET_COUNT;
      else if (counter_reset_on_match_enable && seven_match)
         free_running_count <= RESET_COUNT;
      else if (tick)
         free_running_count <= free_running_count + 16'h0001;
   end

   assign count_out = free_running_count;

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         compare_event <= RESET_CHANNEL_BITS;
      else
         compare_event <= match;
   end

   assign compare_event_out = compare_event;

   // --------------------------------------------------------------------
   // Channel value registers
   // --------------------------------------------------------------------
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         for (int i = 0; i < NUM_CHANNELS; i++)
            channel_value[i] <= RESET_COUNT;
      end
      else
      begin
         for (int i = 0; i < NUM_CHANNELS; i++)
         begin
            if (!channel_mode[i] && capture_event_in[i])
               channel_value[i] <= free_running_count;
            else if (wr && is_channel && channel_sel == 2'(i) && channel_mode[i])
               channel_value[i] <= pwdata_in[COUNT_W-1:0];
         end
      end
   end

   // --------------------------------------------------------------------
   // Event flags
   // --------------------------------------------------------------------
   // fast clear on value access
   always_comb
   begin
      for (int i = 0; i < NUM_CHANNELS; i++)
         fast_clear[i] = fast_flag_clear_all && access && is_channel && channel_sel == 2'(i)
                         && (channel_mode[i] ? pwrite_in : !pwrite_in);
   end

   assign write_clear = (wr && index == IDX_CHANNEL_EVENT_FLAGS) ? take_channels(pwdata_in) : RESET_CHANNEL_BITS;

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         channel_event_flags <= RESET_CHANNEL_BITS;
      else
         channel_event_flags <= (channel_event_flags & ~(write_clear | fast_clear))
                                | (capture_event_in & ~channel_mode) | match;
   end

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         counter_overflow_flag <= 1'b0;
      else if (tick && free_running_count == COUNT_ALL_ONES
               && !(counter_reset_on_match_enable && seven_match))
         counter_overflow_flag <= 1'b1;
      else if (wr && index == IDX_OVERFLOW_FLAG_REGISTER && pwdata_in[BIT_COUNTER_OVERFLOW_FLAG])
         counter_overflow_flag <= 1'b0;
      else if (fast_flag_clear_all && access && index == IDX_FREE_RUNNING_COUNT)
         counter_overflow_flag <= 1'b0;
   end

   // --------------------------------------------------------------------
   // Interrupt
   // --------------------------------------------------------------------
   // per-channel gate
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         irq_out <= 1'b0;
      else
         irq_out <= (|(channel_event_flags & channel_irq_enable))
                    || (counter_overflow_flag && overflow_irq_enable);
   end

endmodule : timer_irq_prescale_flags

// File: timer_irq_prescale_flags_pkg.sv
package timer_irq_prescale_flags_pkg;

   // --------------------------------------------------------------------
   // Widths
   // --------------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned INDEX_W = 6;
   localparam int unsigned COUNT_W = 16;
   localparam int unsigned DIV_SEL_W = 3;
   localparam int unsigned PRESCALE_W = 7;
   localparam int unsigned CHANNELS = 4;
   localparam int unsigned FIRST_CHANNEL = 4;
   localparam int unsigned INDEX_LSB = 2;

   // --------------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // --------------------------------------------------------------------
   localparam logic [INDEX_W-1:0] IDX_CHANNEL_MODE = 6'h00;
   localparam logic [INDEX_W-1:0] IDX_FREE_RUNNING_COUNT = 6'h04;
   localparam logic [INDEX_W-1:0] IDX_TIMER_SYSTEM_CONTROL_ONE = 6'h06;
   localparam logic [INDEX_W-1:0] IDX_CHANNEL_IRQ_ENABLE = 6'h0c;
   localparam logic [INDEX_W-1:0] IDX_TIMER_SYSTEM_CONTROL_TWO = 6'h0d;
   localparam logic [INDEX_W-1:0] IDX_CHANNEL_EVENT_FLAGS = 6'h0e;
   localparam logic [INDEX_W-1:0] IDX_OVERFLOW_FLAG_REGISTER = 6'h0f;
   localparam logic [INDEX_W-1:0] IDX_CHANNEL_VALUE_BASE = 6'h18;
   localparam logic [INDEX_W-1:0] IDX_CHANNEL_VALUE_LAST = 6'h1e;

   // --------------------------------------------------------------------
   // Field positions
   // --------------------------------------------------------------------
   localparam int unsigned BIT_TIMER_ENABLE = 7;
   localparam int unsigned BIT_FAST_FLAG_CLEAR_ALL = 4;
   localparam int unsigned BIT_OVERFLOW_IRQ_ENABLE = 7;
   localparam int unsigned BIT_COUNTER_RESET_ON_MATCH_ENABLE = 3;
   localparam int unsigned BIT_CLOCK_DIVIDE_SELECT_LSB = 0;
   localparam int unsigned BIT_COUNTER_OVERFLOW_FLAG = 7;
   localparam int unsigned BIT_CHANNEL_LSB = 4;

   // --------------------------------------------------------------------
   // Reset values and the all-ones count
   // --------------------------------------------------------------------
   localparam logic [CHANNELS-1:0] RESET_CHANNEL_BITS = 4'h0;
   localparam logic [COUNT_W-1:0] RESET_COUNT = 16'h0000;
   localparam logic [DIV_SEL_W-1:0] RESET_DIVIDE = 3'h0;
   localparam logic [PRESCALE_W-1:0] RESET_PRESCALE = 7'h00;
   localparam logic [COUNT_W-1:0] COUNT_ALL_ONES = 16'hffff;

endpackage : timer_irq_prescale_flags_pkg

// File: timer_irq_prescale_flags_asserts.sv
`timescale 1ns/10ps
module timer_irq_prescale_flags_asserts
   import timer_irq_prescale_flags_pkg::*;
#(
   parameter int unsigned NUM_CHANNELS = CHANNELS
)
(
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic [ADDR_W-1:0] paddr_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [DATA_W-1:0] pwdata_in,
   input wire logic [DATA_W-1:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic [NUM_CHANNELS-1:0] capture_event_in,
   input wire logic [COUNT_W-1:0] count_out,
   input wire logic [NUM_CHANNELS-1:0] compare_event_out,
   input wire logic irq_out
);
   // ---------------------------------------------------------------
   // Mirrors of software written settings and of the channel 7 value, captures included
   // ---------------------------------------------------------------
   logic [3:0] ien_m;
   logic ovf_ien_m;
   logic wrap_en_m;
   logic [3:0] mode_m;
   logic [15:0] c7_m;
   logic wr;
   logic [INDEX_W-1:0] idx;
   assign wr = psel_in && penable_in && pwrite_in;
   assign idx = paddr_in[7:2];
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         ien_m <= 4'h0;
         ovf_ien_m <= 1'b0;
         wrap_en_m <= 1'b0;
         mode_m <= 4'h0;
         c7_m <= 16'h0000;
      end
      else
      begin
         if (wr && idx == IDX_CHANNEL_IRQ_ENABLE)
            ien_m <= pwdata_in[7:4];
         if (wr && idx == IDX_TIMER_SYSTEM_CONTROL_TWO)
            ovf_ien_m <= pwdata_in[7];
         if (wr && idx == IDX_TIMER_SYSTEM_CONTROL_TWO)
            wrap_en_m <= pwdata_in[3];
         if (wr && idx == IDX_CHANNEL_MODE)
            mode_m <= pwdata_in[7:4];
         if (wr && idx == IDX_CHANNEL_VALUE_LAST && mode_m[3])
            c7_m <= pwdata_in[15:0];
         else if (capture_event_in[3] && !mode_m[3])
            c7_m <= count_out;
      end
   end
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!reset_n_in);
   property p_ready; psel_in && penable_in |-> pready_out; endproperty
   a_ready: assert property (p_ready) else $error("no ready in access");
   property p_mapped; psel_in && penable_in && (idx == IDX_CHANNEL_IRQ_ENABLE ||
      idx == IDX_TIMER_SYSTEM_CONTROL_TWO) |-> !pslverr_out; endproperty
   a_mapped: assert property (p_mapped) else $error("error on mapped register");
   property p_readback; psel_in && penable_in && !pwrite_in && idx == IDX_CHANNEL_IRQ_ENABLE
      |-> prdata_out == {24'h0, ien_m, 4'h0}; endproperty
   a_readback: assert property (p_readback) else $error("enable read back wrong");
   property p_step; !$stable(count_out) |-> count_out == $past(count_out) + 16'h1 || count_out == 16'h0; endproperty
   a_step: assert property (p_step) else $error("counter jumped");
   property p_wrap; wrap_en_m && mode_m[3] && c7_m != 16'h0 && count_out == c7_m ##1 !$stable(count_out)
      |-> count_out == 16'h0; endproperty
   a_wrap: assert property (p_wrap) else $error("no restart on match");
   property p_hold; wrap_en_m && mode_m[3] && c7_m == 16'h0 && count_out == 16'h0 |=> count_out == 16'h0; endproperty
   a_hold: assert property (p_hold) else $error("counter left zero");
   property p_cmp; compare_event_out[3] |-> $past(count_out) == $past(c7_m); endproperty
   a_cmp: assert property (p_cmp) else $error("compare without match");
   property p_cause; $rose(irq_out) |-> $past(ien_m) != 4'h0 || $past(ovf_ien_m); endproperty
   a_cause: assert property (p_cause) else $error("interrupt while all disabled");
   property p_capture; capture_event_in[0] && !mode_m[0] && ien_m[0] |-> ##2 irq_out; endproperty
   a_capture: assert property (p_capture) else $error("capture raised no interrupt");
   c_irq: cover property ($rose(irq_out));
   c_cmp: cover property (compare_event_out[3]);
   c_err: cover property (pslverr_out);
endmodule : timer_irq_prescale_flags_asserts

bind timer_irq_prescale_flags timer_irq_prescale_flags_asserts #(.NUM_CHANNELS(NUM_CHANNELS)) u_asserts (
   .clock_in(clock_in), .reset_n_in(reset_n_in), .paddr_in(paddr_in), .psel_in(psel_in),
   .penable_in(penable_in), .pwrite_in(pwrite_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
   .pready_out(pready_out), .pslverr_out(pslverr_out), .capture_event_in(capture_event_in),
   .count_out(count_out), .compare_event_out(compare_event_out), .irq_out(irq_out));

// File: timer_irq_prescale_flags_bench.sv
`timescale 1ns/10ps
module timer_irq_prescale_flags_bench
   import timer_irq_prescale_flags_pkg::*;
();
   localparam logic [7:0] a_mode = {IDX_CHANNEL_MODE, 2'b00};
   localparam logic [7:0] a_ctl1 = {IDX_TIMER_SYSTEM_CONTROL_ONE, 2'b00};
   localparam logic [7:0] a_ien = {IDX_CHANNEL_IRQ_ENABLE, 2'b00};
   localparam logic [7:0] a_ctl2 = {IDX_TIMER_SYSTEM_CONTROL_TWO, 2'b00};
   localparam logic [7:0] a_flg = {IDX_CHANNEL_EVENT_FLAGS, 2'b00};
   localparam logic [7:0] a_ovf = {IDX_OVERFLOW_FLAG_REGISTER, 2'b00};
   localparam logic [7:0] a_v5 = {IDX_CHANNEL_VALUE_BASE + 6'h02, 2'b00};
   localparam logic [7:0] a_v7 = {IDX_CHANNEL_VALUE_LAST, 2'b00};
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [3:0] capture = 4'h0;
   logic [15:0] count;
   logic [3:0] compare_event;
   logic irq;
   logic [31:0] last_rd;
   logic last_err;
   int n_mismatch = 0;
   int checked = 0;
   int cyc = 0;
   int s;
   int t0;
   int t1;
   timer_irq_prescale_flags #(.NUM_CHANNELS(CHANNELS)) dut (.clock_in(clock), .reset_n_in(reset_n),
      .paddr_in(paddr), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .capture_event_in(capture),
      .count_out(count), .compare_event_out(compare_event), .irq_out(irq));
   initial
   begin
      forever #20 clock = ~clock;
   end
   always @(posedge clock) cyc <= cyc + 1;
   task stop_test;
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : stop_test
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task timeout;
      n_mismatch++;
      $display("Error %0t: wait timed out", $time);
      stop_test();
   endtask : timeout
   task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int i;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      for (i = 0; i < 16; i++)
      begin
         @(posedge clock);
         if (pready === 1'b1)
            break;
      end
      if (i == 16)
         timeout();
      last_rd = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask : wr
   task rd_chk(input logic [7:0] a, input logic [31:0] e);
      apb(a, 1'b0, 32'h0);
      check(last_rd, e);
   endtask : rd_chk
   task pulse(input logic [3:0] v);
      @(posedge clock);
      capture <= v;
      @(posedge clock);
      capture <= 4'h0;
   endtask : pulse
   task do_reset;
      reset_n <= 1'b0;
      repeat (8) @(posedge clock);
      reset_n <= 1'b1;
   endtask : do_reset
   task next_change(output int at);
      logic [15:0] p;
      int i;
      p = count;
      for (i = 0; i < 400; i++)
      begin
         @(posedge clock);
         if (count !== p)
            break;
      end
      if (i == 400)
         timeout();
      at = cyc;
   endtask : next_change
   task wait_count(input logic [15:0] v);
      int i;
      for (i = 0; i < 70000; i++)
      begin
         @(posedge clock);
         if (count === v)
            break;
      end
      if (i == 70000)
         timeout();
   endtask : wait_count
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      do_reset();
      rd_chk(a_ien, 32'h0);
      rd_chk(a_ctl2, 32'h0);
      rd_chk(a_flg, 32'h0);
      wr(a_ien, 32'hffffffff);
      rd_chk(a_ien, 32'hf0);
      wr(a_ctl2, 32'hff);
      rd_chk(a_ctl2, 32'h8f);
      wr(a_ctl2, 32'h0);
      apb(8'h04, 1'b0, 32'h0);
      check(last_err, 1'b1);
      wr(a_ien, 32'h10);
      pulse(4'b0101);
      rd_chk(a_flg, 32'h50);
      check(irq, 1'b1);
      wr(a_ien, 32'h0);
      repeat (2) @(posedge clock);
      check(irq, 1'b0);
      wr(a_flg, 32'h10);
      rd_chk(a_flg, 32'h40);
      wr(a_flg, 32'h0);
      rd_chk(a_flg, 32'h40);
      wr(a_ien, 32'h40);
      repeat (2) @(posedge clock);
      check(irq, 1'b1);
      wr(a_flg, 32'h40);
      repeat (2) @(posedge clock);
      check(irq, 1'b0);
      wr(a_ctl1, 32'h10);
      pulse(4'b0010);
      rd_chk(a_flg, 32'h20);
      rd_chk(a_v5, 32'h0);
      rd_chk(a_flg, 32'h0);
      wr(a_ctl1, 32'h80);
      for (s = 0; s < 8; s++)
      begin
         wr(a_ctl2, s);
         next_change(t0);
         next_change(t0);
         next_change(t1);
         check(t1 - t0, 1 << s);
      end
      next_change(t0);
      wr(a_ctl2, 32'h0);
      next_change(t1);
      check(t1 - t0, 128);
      wr(a_mode, 32'h80);
      // Compare value above the present count, so no full wrap is needed
      wr(a_v7, 32'h100);
      wr(a_ctl2, 32'h08);
      wr(a_flg, 32'hf0);
      wait_count(16'h0100);
      next_change(t0);
      check(count, 16'h0000);
      rd_chk(a_flg, 32'h80);
      do_reset();
      wr(a_mode, 32'h80);
      wr(a_ctl2, 32'h08);
      wr(a_ctl1, 32'h80);
      repeat (20) @(posedge clock);
      check(count, 16'h0000);
      rd_chk(a_flg, 32'h80);
      wr(a_ctl2, 32'h80);
      wait_count(16'hffff);
      repeat (3) @(posedge clock);
      check(irq, 1'b1);
      rd_chk(a_ovf, 32'h80);
      wr(a_ovf, 32'h80);
      rd_chk(a_ovf, 32'h0);
      check(irq, 1'b0);
      stop_test();
   end
endmodule : timer_irq_prescale_flags_bench
